/* File: hw/motor_parameter_store.sv */
// Working and non-volatile parameter store with a classic Wishbone slave.
//
// Contract
// RQ1 - Volatile working copy and retained non-volatile copy.
// RQ2 - Power-up loads working copy, then recalculates.
// RQ3 - Bus writes change only the working copy.
// RQ4 - Commit command copies working set to non-volatile.
// RQ5 - Class A values apply at write.
// RQ6 - Class B values apply once motor stops.
// RQ7 - Class C applies on configure or power-up.
// RQ8 - Class D applies only at power-up.
// RQ9 - Host commits power-up parameters before power-off.
// RQ10 - Host limits commits to about 100,000.
// RQ11 - Sixteen sets: speed, acceleration, deceleration, torque.
// RQ12 - Speed range depends on setting; initial zero.
// RQ13 - Acceleration 0.2 to 15 s, default 0.5 s.
// RQ14 - Deceleration defaults to 0.5 s.
// RQ15 - Torque limit 0 to 200 percent, default 200.
// RQ16 - Acceleration span: set speed or rated speed.
// RQ17 - Deceleration span: set speed or rated speed.
`default_nettype none
module motor_parameter_store
  import param_store_pkg::*;
(
  // Clock and reset
  input  wire  logic                  ref_clk,
  input  wire  logic                  rstn,
  // Wishbone slave
  input  wire  logic                  wb_cyc_i,
  input  wire  logic                  wb_stb_i,
  input  wire  logic                  wb_we_i,
  input  wire  logic [9:0]            wb_adr_i,
  input  wire  logic [3:0]            wb_sel_i,
  input  wire  logic [31:0]           wb_dat_i,
  output var   logic [31:0]           wb_dat_o,
  output var   logic                  wb_ack_o,
  // Motor side
  input  wire  logic                  motor_running,
  input  wire  logic [3:0]            op_sel,
  output var   logic [15:0]           set_speed,
  output var   logic [15:0]           set_accel,
  output var   logic [15:0]           set_decel,
  output var   logic [15:0]           set_torque,
  output var   logic [15:0]           ramp_span,
  output var   logic [N_USER*16-1:0]  user_eff,
  output var   logic                  store_busy
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    fsm_t                 st;
    logic [6:0]           idx;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 digital;
    logic                 range_err;
    logic                 pend_b;
    logic                 pend_c;
    logic                 pend_d;
    logic [15:0]          commits;
    logic [N_USER*16-1:0] user_work;
    logic [N_USER*16-1:0] user_eff;
    logic [15:0]          speed;
    logic [15:0]          accel;
    logic [15:0]          decel;
    logic [15:0]          torque;
    logic [15:0]          span;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Working operation data is plain RAM; the non-volatile arrays have no reset.
  logic [15:0] op_work [N_OP];
  logic [15:0] nv_op   [N_OP];
  logic [15:0] nv_user [N_USER];

  logic        op_we;
  logic [5:0]  op_waddr;
  logic [15:0] op_wdata;
  logic        nv_we;
  logic [6:0]  nv_waddr;
  logic [15:0] nv_wdata;

  logic        req;
  logic        wr;
  logic        wr16;
  logic [7:0]  word;
  logic [15:0] wval;
  logic [5:0]  op_idx;
  logic [1:0]  fld;
  logic [2:0]  uidx;
  logic        in_op;
  logic        in_user;
  logic        in_eff;
  logic        val_ok;
  logic [15:0] speed_min;
  logic [1:0]  cls;
  logic        apply_b;
  logic        apply_c;
  logic [5:0]  sel_base;
  logic [15:0] sel_speed;

  // ********************************
  // Non-volatile contents as shipped
  // ********************************
  // Shipped contents are the default operation data and zeroed user parameters.
  initial begin
    for (int i = 0; i < N_OP; i++) begin
      case (i % N_FIELDS)
        FLD_SPEED:  nv_op[i] = DEF_SPEED;
        FLD_TORQUE: nv_op[i] = DEF_TORQUE;
        default:    nv_op[i] = DEF_RAMP;
      endcase
    end
    for (int i = 0; i < N_USER; i++) begin
      nv_user[i] = DEF_USER;
    end
  end

  // ********************************
  // Decode
  // ********************************
  // A request is taken only while idle and with ack low, so each transfer is answered once.
  assign req       = wb_cyc_i & wb_stb_i & ~s_q.ack & (s_q.st == ST_IDLE);
  assign wr        = req & wb_we_i;
  assign wr16      = wr & (wb_sel_i[1:0] == 2'b11);
  assign word      = wb_adr_i[9:2];
  assign wval      = wb_dat_i[15:0];
  assign in_op     = (wb_adr_i[9:8] == ADR_OP_BASE[9:8]);
  assign in_user   = (wb_adr_i[9:5] == ADR_USER_BASE[9:5]);
  assign in_eff    = (wb_adr_i[9:5] == ADR_EFF_BASE[9:5]);
  assign op_idx    = word[5:0];
  assign fld       = word[1:0];
  assign uidx      = word[2:0];
  assign speed_min = s_q.digital ? SPEED_MIN_DIGITAL : SPEED_MIN_ANALOG;
  assign cls       = USER_CLASSES[uidx*2 +: 2];
  assign sel_base  = {op_sel, 2'b00};
  assign sel_speed = op_work[sel_base + 6'(FLD_SPEED)];

  // Range check of a set field written by the host.
  always_comb begin
    case (fld)
      // RQ12 speed range check
      2'(FLD_SPEED):  val_ok = (wval >= speed_min) && (wval <= SPEED_MAX);
      // RQ13 acceleration range check
      2'(FLD_ACCEL):  val_ok = (wval >= RAMP_MIN) && (wval <= RAMP_MAX);
      // RQ14 deceleration range check
      2'(FLD_DECEL):  val_ok = (wval >= RAMP_MIN) && (wval <= RAMP_MAX);
      // RQ15 torque range check
      default:        val_ok = (wval <= TORQUE_MAX);
    endcase
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    s_d      = s_q;
    op_we    = 1'b0;
    op_waddr = op_idx;
    op_wdata = wval;
    nv_we    = 1'b0;
    nv_waddr = s_q.idx;
    nv_wdata = 16'h0000;
    apply_b  = 1'b0;
    apply_c  = 1'b0;
    s_d.ack  = req;

    case (s_q.st)
      // RQ2 load from non-volatile
      ST_LOAD: begin
        if (s_q.idx < 7'(N_OP)) begin
          op_we    = 1'b1;
          op_waddr = s_q.idx[5:0];
          op_wdata = nv_op[s_q.idx[5:0]];
        end else begin
          s_d.user_work[(s_q.idx - 7'(N_OP))*16 +: 16] = nv_user[3'(s_q.idx - 7'(N_OP))];
        end
        s_d.idx = s_q.idx + 7'd1;
        if (s_q.idx == 7'(N_ALL - 1)) begin
          s_d.st = ST_RECALC;
        end
      end
      // RQ2 recalculation after load
      ST_RECALC: begin
        // RQ8 class D applies here
        s_d.user_eff = s_q.user_work;
        s_d.idx      = 7'd0;
        s_d.st       = ST_IDLE;
      end
      // RQ4 copy working set to non-volatile
      ST_COMMIT: begin
        // Bus requests wait while busy, so the working copy cannot change under the copy.
        nv_we = 1'b1;
        if (s_q.idx < 7'(N_OP)) begin
          nv_wdata = op_work[s_q.idx[5:0]];
        end else begin
          nv_wdata = s_q.user_work[(s_q.idx - 7'(N_OP))*16 +: 16];
        end
        s_d.idx = s_q.idx + 7'd1;
        if (s_q.idx == 7'(N_ALL - 1)) begin
          s_d.idx     = 7'd0;
          s_d.commits = s_q.commits + 16'd1;
          s_d.st      = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[0]) begin
          s_d.digital = wb_dat_i[CTRL_DIGITAL];
          if (wb_dat_i[CTRL_COMMIT]) begin
            s_d.idx = 7'd0;
            s_d.st  = ST_COMMIT;
          end
          apply_c = wb_dat_i[CTRL_CONFIG];
        end
        // The clear comes first so that a new range error in the same cycle wins.
        if (wr && (wb_adr_i == ADR_STATUS) && wb_sel_i[0] && wb_dat_i[ST_RANGE_ERR]) begin
          s_d.range_err = 1'b0;
        end
        // Refused values are acknowledged but leave the working copy unchanged.
        // RQ3 bus writes reach RAM only
        if (wr16 && in_op) begin
          if (val_ok) begin
            op_we = 1'b1;
          end else begin
            s_d.range_err = 1'b1;
          end
        end
        // RQ7 configure applies class C
        if (apply_c) begin
          s_d.pend_c = 1'b0;
        end
        // RQ6 class B waits for stop
        apply_b = s_q.pend_b & ~motor_running;
        if (apply_b) begin
          s_d.pend_b = 1'b0;
        end
        // Released stop-class and configure-class entries take their working value.
        for (int i = 0; i < N_USER; i++) begin
          if ((apply_b && (USER_CLASSES[i*2 +: 2] == 2'(CLS_B))) ||
              (apply_c && (USER_CLASSES[i*2 +: 2] == 2'(CLS_C)))) begin
            s_d.user_eff[i*16 +: 16] = s_q.user_work[i*16 +: 16];
          end
        end
        if (wr16 && in_user) begin
          s_d.user_work[uidx*16 +: 16] = wval;
          case (upd_class_t'(cls))
            // RQ5 class A applies at once
            CLS_A:   s_d.user_eff[uidx*16 +: 16] = wval;
            CLS_B:   s_d.pend_b = 1'b1;
            CLS_C:   s_d.pend_c = 1'b1;
            // RQ8 class D held until power-up
            default: s_d.pend_d = 1'b1;
          endcase
        end
      end
      default: begin
        s_d.st = ST_LOAD;
      end
    endcase

    // Read data.
    s_d.rdata = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (wb_adr_i == ADR_CTRL) begin
        s_d.rdata[CTRL_DIGITAL] = s_q.digital;
      end else if (wb_adr_i == ADR_STATUS) begin
        s_d.rdata[ST_BUSY]      = (s_q.st != ST_IDLE);
        s_d.rdata[ST_RANGE_ERR] = s_q.range_err;
        s_d.rdata[ST_PEND_B]    = s_q.pend_b;
        s_d.rdata[ST_PEND_C]    = s_q.pend_c;
        s_d.rdata[ST_PEND_D]    = s_q.pend_d;
        s_d.rdata[ST_RUNNING]   = motor_running;
      end else if (wb_adr_i == ADR_COMMITS) begin
        s_d.rdata[15:0] = s_q.commits;
      end else if (in_op) begin
        s_d.rdata[15:0] = op_work[op_idx];
      end else if (in_user) begin
        s_d.rdata[15:0] = s_q.user_work[uidx*16 +: 16];
      end else if (in_eff) begin
        s_d.rdata[15:0] = s_q.user_eff[uidx*16 +: 16];
      end
    end

    // RQ11 selected set drives the motor
    s_d.speed  = sel_speed;
    s_d.accel  = op_work[sel_base + 6'(FLD_ACCEL)];
    s_d.decel  = op_work[sel_base + 6'(FLD_DECEL)];
    s_d.torque = op_work[sel_base + 6'(FLD_TORQUE)];
    // RQ16 RQ17 ramp reference speed
    s_d.span   = s_q.digital ? sel_speed : RATED_SPEED;
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // RQ1 working and retained arrays
  always_ff @(posedge ref_clk) begin
    if (op_we) begin
      op_work[op_waddr] <= op_wdata;
    end
  end

  // The retained arrays also get their shipped contents from the initial block,
  // so they are written from a plain clocked process that may share its targets.
  always @(posedge ref_clk) begin
    if (nv_we && (nv_waddr < 7'(N_OP))) begin
      nv_op[nv_waddr[5:0]] <= nv_wdata;
    end
    if (nv_we && (nv_waddr >= 7'(N_OP))) begin
      nv_user[3'(nv_waddr - 7'(N_OP))] <= nv_wdata;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign wb_ack_o   = s_q.ack;
  assign wb_dat_o   = s_q.rdata;
  assign set_speed  = s_q.speed;
  assign set_accel  = s_q.accel;
  assign set_decel  = s_q.decel;
  assign set_torque = s_q.torque;
  assign ramp_span  = s_q.span;
  assign user_eff   = s_q.user_eff;
  assign store_busy = (s_q.st != ST_IDLE);

endmodule // motor_parameter_store
`default_nettype wire

/* File: pkg/param_store_pkg.sv */
// Constants, types and register map of the motor parameter store.
`default_nettype none
package param_store_pkg;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [9:0] ADR_CTRL      = 10'h000;
  localparam logic [9:0] ADR_STATUS    = 10'h004;
  localparam logic [9:0] ADR_COMMITS   = 10'h008;
  localparam logic [9:0] ADR_OP_BASE   = 10'h100;
  localparam logic [9:0] ADR_USER_BASE = 10'h200;
  localparam logic [9:0] ADR_EFF_BASE  = 10'h240;

  // ********************************
  // Field positions
  // ********************************
  localparam int CTRL_DIGITAL  = 0;
  localparam int CTRL_COMMIT   = 1;
  localparam int CTRL_CONFIG   = 2;
  localparam int ST_BUSY       = 0;
  localparam int ST_RANGE_ERR  = 1;
  localparam int ST_PEND_B     = 2;
  localparam int ST_PEND_C     = 3;
  localparam int ST_PEND_D     = 4;
  localparam int ST_RUNNING    = 5;

  // ********************************
  // Sizes
  // ********************************
  localparam int N_SETS   = 16;
  localparam int N_FIELDS = 4;
  localparam int N_OP     = N_SETS * N_FIELDS;
  localparam int N_USER   = 8;
  localparam int N_ALL    = N_OP + N_USER;
  localparam int FLD_SPEED  = 0;
  localparam int FLD_ACCEL  = 1;
  localparam int FLD_DECEL  = 2;
  localparam int FLD_TORQUE = 3;

  // ********************************
  // Value ranges and defaults (speed r/min, times 0.1 s, torque %)
  // ********************************
  localparam logic [15:0] SPEED_MIN_ANALOG  = 16'h0064;
  localparam logic [15:0] SPEED_MIN_DIGITAL = 16'h0050;
  localparam logic [15:0] SPEED_MAX         = 16'h0FA0;
  localparam logic [15:0] RATED_SPEED       = 16'h0BB8;
  localparam logic [15:0] RAMP_MIN          = 16'h0002;
  localparam logic [15:0] RAMP_MAX          = 16'h0096;
  localparam logic [15:0] TORQUE_MAX        = 16'h00C8;
  localparam logic [15:0] DEF_SPEED         = 16'h0000;
  localparam logic [15:0] DEF_RAMP          = 16'h0005;
  localparam logic [15:0] DEF_TORQUE        = 16'h00C8;
  localparam logic [15:0] DEF_USER          = 16'h0000;

  // ********************************
  // Update classes of the user parameters, two bits each, entry 0 lowest
  // ********************************
  typedef enum logic [1:0] {CLS_A, CLS_B, CLS_C, CLS_D} upd_class_t;
  localparam logic [15:0] USER_CLASSES = 16'hFA50;

  typedef enum logic [2:0] {ST_LOAD, ST_RECALC, ST_IDLE, ST_COMMIT} fsm_t;

endpackage
`default_nettype wire

/* File: test/store_checker.sv */
// Port-level assertions for the motor parameter store.
`default_nettype none
module store_checker
  import param_store_pkg::*;
(
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rstn,
  // Register bus
  input wire logic                 wb_ack_o,
  input wire logic [31:0]          wb_dat_o,
  // Motor side
  input wire logic                 motor_running,
  input wire logic [15:0]          set_speed,
  input wire logic [15:0]          set_accel,
  input wire logic [15:0]          set_decel,
  input wire logic [15:0]          set_torque,
  input wire logic [15:0]          ramp_span,
  input wire logic [N_USER*16-1:0] user_eff,
  input wire logic                 store_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ********************************
  // Assertions
  // ********************************
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data driven without ack");
  a_quiet_busy: assert property (store_busy && $past(store_busy) |-> !wb_ack_o)
    else $error("bus answered while the store was busy");
  a_load_busy: assert property (!$past(rstn) |-> ##2 store_busy [*8])
    else $error("no power-up load after reset");
  a_busy_bound: assert property ($rose(store_busy) |-> ##[1:80] !store_busy)
    else $error("busy phase too long");
  a_ramp_span: assert property (!store_busy && ramp_span != RATED_SPEED |-> ramp_span == set_speed)
    else $error("ramp span neither rated nor set speed");
  a_torque_range: assert property (!store_busy && !$past(store_busy) |-> set_torque <= TORQUE_MAX)
    else $error("torque limit out of range");
  a_ramp_range: assert property (!store_busy && !$past(store_busy) |-> set_accel >= RAMP_MIN
    && set_accel <= RAMP_MAX && set_decel >= RAMP_MIN && set_decel <= RAMP_MAX)
    else $error("ramp time out of range");
  a_class_b: assert property (!store_busy && motor_running && $past(motor_running)
    |-> $stable(user_eff[63:32]))
    else $error("stop-class value applied while running");
  a_class_d: assert property (!store_busy && !$past(store_busy) |-> $stable(user_eff[127:96]))
    else $error("power-up class value changed at run time");
  c_load_done: cover property ($fell(store_busy));
  c_class_b: cover property (!motor_running && $changed(user_eff[63:32]));
  c_digital: cover property (!store_busy && ramp_span != RATED_SPEED);
endmodule // store_checker
bind motor_parameter_store store_checker i_store_checker (
  .ref_clk, .rstn, .wb_ack_o, .wb_dat_o, .motor_running, .set_speed, .set_accel,
  .set_decel, .set_torque, .ramp_span, .user_eff, .store_busy
);
`default_nettype wire

/* File: test/motor_model.sv */
// Behavioural motor that runs on request and coasts a few cycles before it stops.
`default_nettype none
module motor_model #(
  parameter int STOP_CYC = 4
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Run control
  input  wire logic run_req,
  output var  logic motor_running
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      cnt <= 0;
    else if (run_req)
      cnt <= STOP_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign motor_running = (cnt != 0);
endmodule // motor_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the motor parameter store.
`default_nettype none
module tb
  import param_store_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [9:0]           wb_adr_i = 10'h000;
  logic [3:0]           wb_sel_i = 4'h0;
  logic [31:0]          wb_dat_i = 32'h0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 run_req = 1'b0;
  logic                 motor_running;
  logic [3:0]           op_sel = 4'h0;
  logic [15:0]          set_speed, set_accel, set_decel, set_torque, ramp_span;
  logic [N_USER*16-1:0] user_eff;
  logic                 store_busy;
  logic [31:0]          q;
  logic [31:0]          c0;
  int                   err_total = 0;
  int                   cmp_count = 0;
  // Address, write value (FFFF means read only), value read back.
  localparam logic [41:0] ROWS [0:17] = '{
    {10'h100, 16'hFFFF, 16'h0000}, {10'h104, 16'hFFFF, 16'h0005}, {10'h108, 16'hFFFF, 16'h0005},
    {10'h10C, 16'hFFFF, 16'h00C8}, {10'h1F0, 16'hFFFF, 16'h0000}, {10'h1FC, 16'hFFFF, 16'h00C8},
    {10'h100, 16'h0063, 16'h0000}, {10'h100, 16'h0064, 16'h0064}, {10'h100, 16'h0FA1, 16'h0064},
    {10'h100, 16'h0FA0, 16'h0FA0}, {10'h104, 16'h0001, 16'h0005}, {10'h104, 16'h0096, 16'h0096},
    {10'h108, 16'h0097, 16'h0005}, {10'h108, 16'h0002, 16'h0002}, {10'h10C, 16'h00C9, 16'h00C8},
    {10'h10C, 16'h0000, 16'h0000}, {10'h3F0, 16'h1234, 16'h0000},
    {10'h100, 16'h0050, 16'h0FA0}};
  motor_parameter_store i_motor_parameter_store (
    .ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .motor_running, .op_sel, .set_speed, .set_accel, .set_decel,
    .set_torque, .ramp_span, .user_eff, .store_busy
  );
  motor_model i_motor_model (.ref_clk, .rstn, .run_req, .motor_running);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {16'h0, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    wb(1'b0, a, 16'h0);
    chk(q, exp);
  endtask
  task automatic power_cycle();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********************************
  // Sequence
  // ********************************
  initial begin
    power_cycle();
    foreach (ROWS[i]) begin
      if (ROWS[i][31:16] != 16'hFFFF)
        wb(1'b1, ROWS[i][41:32], ROWS[i][31:16]);
      rd_chk(ROWS[i][41:32], {16'h0, ROWS[i][15:0]});
    end
    rd_chk(ADR_STATUS, 32'h2);
    wb(1'b1, ADR_STATUS, 16'h0002);
    rd_chk(ADR_STATUS, 32'h0);
    chk({16'h0, ramp_span}, {16'h0, RATED_SPEED});
    wb(1'b1, ADR_CTRL, 16'h1);
    wb(1'b1, 10'h110, 16'h0050);
    op_sel <= 4'h1;
    repeat (3) @(negedge ref_clk);
    chk({16'h0, set_speed}, 32'h50);
    chk({16'h0, set_accel}, {16'h0, DEF_RAMP});
    chk({16'h0, set_decel}, {16'h0, DEF_RAMP});
    chk({16'h0, ramp_span}, 32'h50);
    chk({16'h0, set_torque}, {16'h0, DEF_TORQUE});
    wb(1'b1, ADR_USER_BASE, 16'h0007);
    rd_chk(ADR_EFF_BASE, 32'h7);
    chk({16'h0, user_eff[15:0]}, 32'h7);
    run_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wb(1'b1, 10'h208, 16'h0009);
    rd_chk(10'h248, 32'h0);
    wb(1'b0, ADR_STATUS, 16'h0);
    chk(q & 32'h24, 32'h24);
    run_req <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rd_chk(10'h248, 32'h9);
    wb(1'b1, 10'h20C, 16'h0044);
    rd_chk(10'h24C, 32'h44);
    wb(1'b1, 10'h210, 16'h0011);
    rd_chk(10'h250, 32'h0);
    wb(1'b1, ADR_CTRL, 16'h5);
    rd_chk(10'h250, 32'h11);
    wb(1'b1, 10'h218, 16'h0022);
    wb(1'b1, ADR_CTRL, 16'h5);
    rd_chk(10'h258, 32'h0);
    wb(1'b0, ADR_COMMITS, 16'h0);
    c0 = {16'h0, q[15:0] + 16'h1};
    wb(1'b1, ADR_CTRL, 16'h3);
    @(negedge ref_clk);
    chk({31'h0, store_busy}, 32'h1);
    rd_chk(ADR_COMMITS, c0);
    wb(1'b1, 10'h204, 16'h0033);
    power_cycle();
    @(negedge ref_clk);
    chk({31'h0, store_busy}, 32'h1);
    chk({31'h0, wb_ack_o}, 32'h0);
    chk(wb_dat_o, 32'h0);
    chk(user_eff[127:96], 32'h0);
    @(negedge ref_clk);
    chk({31'h0, store_busy}, 32'h1);
    chk(user_eff[31:0], 32'h0);
    rd_chk(10'h258, 32'h22);
    rd_chk(10'h204, 32'h0);
    rd_chk(10'h200, 32'h7);
    rd_chk(10'h110, 32'h50);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
endmodule // tb
`default_nettype wire
